/* File: cic_channel.sv */
// Counter input channel: filters, counters, sampling and Wishbone slave
//
// Function
// - Up/down mode: rising up input adds one
// - Up/down mode: rising down input subtracts one
// - Sample clock captures current counter value
// - Frequency mode counts source rising edges
// - Time-base counter counts ticks continuously
// - Source rising edge latches time-base count
// - Sample reads edge and time-base counts together
// - Count reported with interpolated fraction
// - Per-input filter; off passes input through
// - Filter samples on 80 MHz time base
// - Level propagates only after stable gate time
// - Eight gate settings, off to 5 us
// - Gate-length pulses pass, shorter ones blocked
// - Reset-on-start clears counters at start
// - Without reset-on-start, counting never stops
// - Single input counts up by default
// - Direction bit makes single input count down
// - Hold mode repeats last measured period
// - Zero mode outputs zero without new period
`timescale 1ns/1ps
module cic_channel
    import cic_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic in_a_i,
    input wire logic in_b_i,
    input wire logic sample_clk_i,
    output logic sample_o
);

    typedef enum logic [1:0] {
        DIV_IDLE = 2'h1,
        DIV_RUN = 2'h2
    } cic_div_type;

    localparam int PIN_N = 3;
    localparam int PIN_SMP = 2;
    localparam logic [7:0] TB_STEP = 8'(TB_MHZ);
    localparam logic [7:0] TB_WRAP = 8'(CLK_MHZ);
    localparam logic [3:0] DIV_STEPS = 4'(FRAC_W);
    localparam logic [1:0] EDGE_FULL = 2'h2;

    cic_ctrl_type ctrl;
    cic_sample_type smp;
    logic [PIN_N-1:0] pin_s1;
    logic [PIN_N-1:0] pin_s2;
    logic smp_d;
    logic run_d;
    logic [7:0] tb_acc;
    logic tb_tick;
    logic [1:0] filt;
    logic [1:0] filt_d;
    logic [CNT_W-1:0] evt_cnt;
    logic [CNT_W-1:0] tb_cnt;
    logic [CNT_W-1:0] cap;
    logic [CNT_W-1:0] last_per;
    logic [1:0] edges;
    logic per_new;
    cic_div_type div_st;
    logic [CNT_W:0] rem;
    logic [CNT_W-1:0] den;
    logic [FRAC_W-1:0] quo;
    logic [3:0] div_n;
    logic [FRAC_W-1:0] frac;
    logic ack;

    // ------------------------------------------------------------
    // Input synchronisers and time base
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            smp_d <= 1'b0;
        end
        else
        begin
            pin_s1 <= {sample_clk_i, in_b_i, in_a_i};
            pin_s2 <= pin_s1;
            smp_d <= pin_s2[PIN_SMP];
        end
    end

    // 80 MHz ticks from 250 MHz; a ninth sum bit keeps 240 + 80 from wrapping
    wire [8:0] tb_sum = {1'b0, tb_acc} + {1'b0, TB_STEP};
    wire tb_over = tb_sum >= {1'b0, TB_WRAP};
    wire [8:0] tb_left = tb_sum - {1'b0, TB_WRAP};
    wire [7:0] next_tb_acc = tb_over ? tb_left[7:0] : tb_sum[7:0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tb_acc <= '0;
            tb_tick <= 1'b0;
        end
        else
        begin
            tb_acc <= next_tb_acc;
            tb_tick <= tb_over;
        end
    end

    // ------------------------------------------------------------
    // Glitch filters
    // ------------------------------------------------------------
    wire [2:0] fsel [2];
    assign fsel[0] = ctrl.filt_a;
    assign fsel[1] = ctrl.filt_b;

    for (genvar i = 0; i < 2; i++)
    begin : g_filt
        logic lvl;
        logic [GATE_W-1:0] fcnt;
        wire [GATE_W-1:0] gate = cic_gate_ticks(fsel[i]);
        wire differs = pin_s2[i] != lvl;
        wire stable = fcnt == gate - GATE_W'(1);

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                lvl <= 1'b0;
                fcnt <= '0;
            end
            else if (fsel[i] == FILT_OFF)
            begin
                lvl <= pin_s2[i];
                fcnt <= '0;
            end
            else if (tb_tick)
            begin
                if (!differs)
                    fcnt <= '0;
                else if (stable)
                begin
                    lvl <= pin_s2[i];
                    fcnt <= '0;
                end
                else
                    fcnt <= fcnt + GATE_W'(1);
            end
        end
        assign filt[i] = lvl;
    end

    // ------------------------------------------------------------
    // Event and time-base counters
    // ------------------------------------------------------------
    wire [1:0] rise = filt & ~filt_d;
    wire start = ctrl.run & ~run_d;
    wire clear = start & ctrl.rst_start;
    // Stopped counting only applies when the start clear is wanted
    wire count_en = ctrl.run | ~ctrl.rst_start;
    wire single_dn = ctrl.mode == CIC_SINGLE && ctrl.down;
    wire inc = rise[0] & ~single_dn;
    wire dec = ctrl.mode == CIC_UPDOWN ? rise[1] : rise[0] & single_dn;
    wire [CNT_W-1:0] next_evt_cnt =
        clear ? '0 :
        !count_en || inc == dec ? evt_cnt :
        inc ? evt_cnt + CNT_W'(1) : evt_cnt - CNT_W'(1);
    wire has_per = edges != 2'h0;
    wire per_ev = rise[0] & has_per;
    wire smp_ev = pin_s2[PIN_SMP] & ~smp_d & ctrl.run;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            filt_d <= '0;
            run_d <= 1'b0;
            evt_cnt <= '0;
            tb_cnt <= '0;
        end
        else
        begin
            filt_d <= filt;
            run_d <= ctrl.run;
            evt_cnt <= next_evt_cnt;
            if (clear)
                tb_cnt <= '0;
            else if (tb_tick)
                tb_cnt <= tb_cnt + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Edge capture and period
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cap <= '0;
            last_per <= '0;
            edges <= '0;
            per_new <= 1'b0;
        end
        else
        begin
            if (clear)
                edges <= '0;
            else if (rise[0] && edges != EDGE_FULL)
                edges <= edges + 2'h1;
            if (rise[0])
                cap <= tb_cnt;
            if (per_ev)
                last_per <= tb_cnt - cap;
            // A new period in the sample cycle wins over the clear
            if (per_ev)
                per_new <= 1'b1;
            else if (smp_ev)
                per_new <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sample capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            smp <= '0;
            sample_o <= 1'b0;
        end
        else
        begin
            sample_o <= smp_ev;
            if (smp_ev)
            begin
                smp.cnt <= evt_cnt;
                smp.tb <= tb_cnt;
                smp.cap <= cap;
                smp.per <= ctrl.zero_out && !per_new ? '0 : last_per;
            end
        end
    end

    // ------------------------------------------------------------
    // Fraction of a period since the last edge, 8 bits
    // ------------------------------------------------------------
    // Serial division keeps area small; a sample arriving while the
    // divider runs keeps its counts but the fraction is skipped.
    wire [CNT_W-1:0] since = tb_cnt - cap;
    wire [CNT_W:0] rem2 = {rem[CNT_W-1:0], 1'b0};
    wire rem_ge = rem2 >= {1'b0, den};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_st <= DIV_IDLE;
            rem <= '0;
            den <= '0;
            quo <= '0;
            div_n <= '0;
            frac <= '0;
        end
        else
        begin
            unique case (div_st)
                DIV_IDLE:
                begin
                    if (smp_ev)
                    begin
                        if (edges != EDGE_FULL)
                            frac <= '0;
                        else if (since >= last_per)
                            frac <= '1;
                        else
                        begin
                            rem <= {1'b0, since};
                            den <= last_per;
                            quo <= '0;
                            div_n <= '0;
                            div_st <= DIV_RUN;
                        end
                    end
                end
                DIV_RUN:
                begin
                    rem <= rem_ge ? rem2 - {1'b0, den} : rem2;
                    quo <= {quo[FRAC_W-2:0], rem_ge};
                    div_n <= div_n + 4'h1;
                    if (div_n == DIV_STEPS - 4'h1)
                    begin
                        frac <= {quo[FRAC_W-2:0], rem_ge};
                        div_st <= DIV_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    wire req = cyc_i & stb_i & ~ack;
    wire wr = cyc_i & stb_i & we_i & ack;
    wire [31:0] ctrl_word = {17'h0_0000, ctrl.filt_b, 1'b0, ctrl.filt_a,
        2'h0, ctrl.zero_out, ctrl.rst_start, ctrl.down, ctrl.mode, ctrl.run};
    wire [31:0] stat_word = {27'h000_0000, ctrl.run, div_st == DIV_RUN,
        per_new, filt};
    wire [31:0] rd_word =
        adr_i == ADR_CTRL ? ctrl_word :
        adr_i == ADR_STAT ? stat_word :
        adr_i == ADR_SMP_CNT ? smp.cnt :
        adr_i == ADR_SMP_TB ? smp.tb :
        adr_i == ADR_SMP_CAP ? smp.cap :
        adr_i == ADR_SMP_PER ? smp.per :
        adr_i == ADR_SMP_FRAC ? {24'h00_0000, frac} :
        adr_i == ADR_LIVE_CNT ? evt_cnt : 32'h0000_0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack <= 1'b0;
            dat_o <= '0;
            ctrl <= CTRL_RESET;
        end
        else
        begin
            ack <= req;
            if (req)
                dat_o <= rd_word;
            if (wr && adr_i == ADR_CTRL && sel_i[0])
            begin
                ctrl.run <= dat_i[CB_RUN];
                ctrl.mode <= cic_mode_type'(dat_i[CB_MODE +: 2]);
                ctrl.down <= dat_i[CB_DOWN];
                ctrl.rst_start <= dat_i[CB_RST_START];
                ctrl.zero_out <= dat_i[CB_ZERO_OUT];
            end
            if (wr && adr_i == ADR_CTRL && sel_i[1])
            begin
                ctrl.filt_a <= dat_i[CB_FILT_A +: 3];
                ctrl.filt_b <= dat_i[CB_FILT_B +: 3];
            end
        end
    end
    assign ack_o = ack;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_up_count;
        ctrl.mode == CIC_UPDOWN && count_en && !clear && rise == 2'h1
            |=> evt_cnt == $past(evt_cnt) + CNT_W'(1);
    endproperty
    a_up_count: assert property (p_up_count)
        else $error("up edge did not add one");

    property p_down_count;
        ctrl.mode == CIC_UPDOWN && count_en && !clear && rise == 2'h2
            |=> evt_cnt == $past(evt_cnt) - CNT_W'(1);
    endproperty
    a_down_count: assert property (p_down_count)
        else $error("down edge did not subtract one");

    property p_single_dir;
        ctrl.mode == CIC_SINGLE && count_en && !clear && rise[0]
            |=> evt_cnt == (ctrl.down ? $past(evt_cnt) - CNT_W'(1)
                                      : $past(evt_cnt) + CNT_W'(1));
    endproperty
    a_single_dir: assert property (p_single_dir)
        else $error("single input count went the wrong way");

    property p_sample;
        smp_ev |=> smp.cnt == $past(evt_cnt) && smp.tb == $past(tb_cnt)
            && sample_o;
    endproperty
    a_sample: assert property (p_sample)
        else $error("sample did not capture both counts");

    property p_capture;
        rise[0] |=> cap == $past(tb_cnt);
    endproperty
    a_capture: assert property (p_capture)
        else $error("edge did not latch time base");

    property p_tb_run;
        tb_tick && !clear |=> tb_cnt == $past(tb_cnt) + CNT_W'(1);
    endproperty
    a_tb_run: assert property (p_tb_run)
        else $error("time base counter missed a tick");

    property p_filt_off;
        fsel[0] == FILT_OFF && $past(fsel[0]) == FILT_OFF
            |-> filt[0] == $past(pin_s2[0]);
    endproperty
    a_filt_off: assert property (p_filt_off)
        else $error("filter off did not pass input");

    property p_filt_gate;
        $changed(filt[0]) && $past(fsel[0]) != FILT_OFF
            |-> $past(g_filt[0].fcnt) == $past(g_filt[0].gate) - GATE_W'(1)
                && $past(tb_tick);
    endproperty
    a_filt_gate: assert property (p_filt_gate)
        else $error("filter changed before gate time");

    property p_clear;
        clear |=> evt_cnt == '0 && tb_cnt == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("start did not clear counters");

    property p_zero_out;
        smp_ev && ctrl.zero_out && !per_new |=> smp.per == '0;
    endproperty
    a_zero_out: assert property (p_zero_out)
        else $error("zero mode output not zero");

    property p_div_len;
        div_st == DIV_IDLE ##1 div_st == DIV_RUN
            |-> ##8 div_st == DIV_IDLE;
    endproperty
    a_div_len: assert property (p_div_len)
        else $error("fraction divider wrong length");

    c_updown: cover property (ctrl.mode == CIC_UPDOWN && rise[1] && count_en);
    c_filter: cover property ($rose(filt[0]) && fsel[0] != FILT_OFF);
    c_frac: cover property (div_st == DIV_RUN ##8 frac != '0);
    c_zero: cover property (smp_ev && ctrl.zero_out && !per_new);

endmodule : cic_channel

/* File: cic_pkg.sv */
// Constants, field layouts and types for the counter input channel
package cic_pkg;

    // ------------------------------------------------------------
    // Clock rates and filter gate times
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int TB_MHZ = 80;
    localparam int NS_PER_US = 1000;
    localparam int GATE_NS [0:7] = '{0, 100, 200, 500, 1000, 2000, 4000, 5000};
    localparam logic [2:0] FILT_OFF = 3'h0;
    localparam int CNT_W = 32;
    localparam int FRAC_W = 8;
    localparam int GATE_W = 9;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_SMP_CNT = 8'h08;
    localparam logic [7:0] ADR_SMP_TB = 8'h0C;
    localparam logic [7:0] ADR_SMP_CAP = 8'h10;
    localparam logic [7:0] ADR_SMP_PER = 8'h14;
    localparam logic [7:0] ADR_SMP_FRAC = 8'h18;
    localparam logic [7:0] ADR_LIVE_CNT = 8'h1C;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int CB_RUN = 0;
    localparam int CB_MODE = 1;
    localparam int CB_DOWN = 3;
    localparam int CB_RST_START = 4;
    localparam int CB_ZERO_OUT = 5;
    localparam int CB_FILT_A = 8;
    localparam int CB_FILT_B = 12;

    typedef enum logic [1:0] {
        CIC_SINGLE = 2'h0,
        CIC_UPDOWN = 2'h1,
        CIC_FREQ = 2'h2
    } cic_mode_type;

    typedef struct packed {
        logic run;
        cic_mode_type mode;
        logic down;
        logic rst_start;
        logic zero_out;
        logic [2:0] filt_a;
        logic [2:0] filt_b;
    } cic_ctrl_type;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] tb;
        logic [CNT_W-1:0] cap;
        logic [CNT_W-1:0] per;
    } cic_sample_type;

    localparam cic_ctrl_type CTRL_RESET = '{run: 1'b0, mode: CIC_SINGLE,
        down: 1'b0, rst_start: 1'b1, zero_out: 1'b0, filt_a: FILT_OFF,
        filt_b: FILT_OFF};

    // Gate time in time-base ticks for a filter setting
    function automatic logic [GATE_W-1:0] cic_gate_ticks(input logic [2:0] s);
        cic_gate_ticks = GATE_W'(GATE_NS[s] * TB_MHZ / NS_PER_US);
    endfunction : cic_gate_ticks

endpackage : cic_pkg

/* File: cic_pulse_src.sv */
// Pulse source model standing in for the encoder on the counter pins
`timescale 1ns/1ps
module cic_pulse_src
(
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic line_i,
    input wire logic [7:0] cnt_i,
    input wire logic [15:0] hi_i,
    input wire logic [15:0] lo_i,
    output logic out_a_o,
    output logic out_b_o,
    output logic busy_o
);
    // ------------------------------------------------------------
    // Pulse train
    // ------------------------------------------------------------
    // Both lines are push-pull, so idle low is a driven level
    initial
    begin
        out_a_o = 1'b0;
        out_b_o = 1'b0;
        busy_o = 1'b0;
        forever
        begin
            @(posedge clk_i);
            if (go_i)
            begin
                busy_o <= 1'b1;
                repeat (cnt_i)
                begin
                    if (line_i)
                        out_b_o <= 1'b1;
                    else
                        out_a_o <= 1'b1;
                    repeat (hi_i) @(posedge clk_i);
                    out_a_o <= 1'b0;
                    out_b_o <= 1'b0;
                    repeat (lo_i) @(posedge clk_i);
                end
                busy_o <= 1'b0;
            end
        end
    end
endmodule : cic_pulse_src

/* File: testbench.sv */
// Self-checking testbench for the counter input channel
`timescale 1ns/1ps
module testbench
    import cic_pkg::*;
;
    typedef struct {string name; logic [31:0] exp; int tol;} cic_note_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic ack;
    logic in_a;
    logic in_b;
    logic sclk = 1'b0;
    logic smp_o;
    logic go = 1'b0;
    logic line = 1'b0;
    logic [7:0] cnt = 8'h00;
    logic [15:0] hiw = 16'h0000;
    logic [15:0] low = 16'h0000;
    logic busy;
    logic [31:0] rnd = 32'h0000_2be8;
    logic [31:0] ecnt;
    int fails = 0;
    int n_tests = 0;
    cic_note_type expq[$];

    cic_channel DUT (.clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wdat),
        .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb),
        .ack_o(ack), .in_a_i(in_a), .in_b_i(in_b), .sample_clk_i(sclk),
        .sample_o(smp_o));
    cic_pulse_src u_src (.clk_i(clk), .go_i(go), .line_i(line),
        .cnt_i(cnt), .hi_i(hiw), .lo_i(low), .out_a_o(in_a),
        .out_b_o(in_b), .busy_o(busy));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial
    begin
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [31:0] ctrl(input logic r, input logic [1:0] m,
        input logic d, input logic s, input logic z, input logic [2:0] f);
        ctrl = 32'h0000_0000;
        ctrl[CB_RUN] = r;
        ctrl[CB_MODE +: 2] = m;
        ctrl[CB_DOWN] = d;
        ctrl[CB_RST_START] = s;
        ctrl[CB_ZERO_OUT] = z;
        ctrl[CB_FILT_A +: 3] = f;
    endfunction : ctrl

    task automatic check_word(input cic_note_type nt, input logic [31:0] seen);
        logic [31:0] d;
        d = (seen > nt.exp) ? seen - nt.exp : nt.exp - seen;
        n_tests++;
        if (^seen === 1'bx || d > 32'(nt.tol))
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nt.name, nt.exp, seen);
        end
    endtask : check_word

    // Reads leave their expected word in the queue for the monitor
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
        input string nm, input int tol);
        int k;
        if (!w)
            expq.push_back('{nm, d, tol});
        adr <= a;
        wdat <= d;
        we <= w;
        sel <= 4'hf;
        cyc <= 1'b1;
        stb <= 1'b1;
        k = 0;
        do @(posedge clk); while (ack !== 1'b1 && ++k < 50);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k == 50)
            fails++;
        @(posedge clk);
    endtask : wb

    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
            check_word(expq.pop_front(), rdat);

    // Extra settle time covers the synchroniser and counter stages
    task automatic pulses(input logic b, input logic [7:0] n,
        input logic [15:0] hi, input logic [15:0] lo);
        int k;
        line <= b;
        cnt <= n;
        hiw <= hi;
        low <= lo;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        do @(posedge clk); while (busy === 1'b1 && ++k < 100000);
        repeat (10) @(posedge clk);
    endtask : pulses

    task automatic smp;
        int k;
        logic got;
        got = 1'b0;
        sclk <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk);
            if (k == 3)
                sclk <= 1'b0;
            if (smp_o === 1'b1)
                got = 1'b1;
        end
        n_tests++;
        if (got !== 1'b1)
        begin
            fails++;
            $display("mismatch sample_o expected 1 seen 0");
        end
    endtask : smp

    // Stopping first makes the second write a start of acquisition
    task automatic start(input logic [31:0] c);
        wb(ADR_CTRL, 1'b1, c & ~32'h0000_0001, "", 0);
        wb(ADR_CTRL, 1'b1, c, "", 0);
    endtask : start

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(ADR_CTRL, 1'b0, 32'h0000_0010, "ctrl reset", 0);
        wb(8'h20, 1'b0, 32'h0000_0000, "unmapped", 0);
        wb(ADR_LIVE_CNT, 1'b1, 32'h0000_1234, "", 0);
        wb(ADR_LIVE_CNT, 1'b0, 32'h0000_0000, "live ro", 0);
        start(ctrl(1'b1, CIC_SINGLE, 1'b0, 1'b1, 1'b0, FILT_OFF));
        rnd = lfsr(rnd);
        ecnt = 32'(rnd[1:0]) + 32'h0000_0001;
        pulses(1'b0, 8'(ecnt), 16'(3 + rnd[3:2]), 16'(3 + rnd[5:4]));
        wb(ADR_LIVE_CNT, 1'b0, ecnt, "single up", 0);
        wb(ADR_CTRL, 1'b1, ctrl(1'b1, CIC_SINGLE, 1'b1, 1'b1, 1'b0, FILT_OFF),
            "", 0);
        pulses(1'b0, 8'(ecnt + 32'h0000_0001), 16'h0004, 16'h0003);
        wb(ADR_LIVE_CNT, 1'b0, 32'hffff_ffff, "single down", 0);
        start(ctrl(1'b1, CIC_UPDOWN, 1'b0, 1'b1, 1'b0, FILT_OFF));
        wb(ADR_LIVE_CNT, 1'b0, 32'h0000_0000, "start clear", 0);
        pulses(1'b0, 8'h03, 16'h0004, 16'h0004);
        pulses(1'b1, 8'h01, 16'h0004, 16'h0004);
        wb(ADR_LIVE_CNT, 1'b0, 32'h0000_0002, "up down", 0);
        pulses(1'b1, 8'h03, 16'h0003, 16'h0005);
        wb(ADR_LIVE_CNT, 1'b0, 32'hffff_ffff, "underflow", 0);
        wb(ADR_CTRL, 1'b1, ctrl(1'b0, CIC_SINGLE, 1'b0, 1'b0, 1'b0, FILT_OFF),
            "", 0);
        pulses(1'b0, 8'h02, 16'h0004, 16'h0004);
        wb(ADR_LIVE_CNT, 1'b0, 32'h0000_0001, "stopped", 0);
        wb(ADR_CTRL, 1'b1, ctrl(1'b1, CIC_SINGLE, 1'b0, 1'b0, 1'b0, FILT_OFF),
            "", 0);
        wb(ADR_LIVE_CNT, 1'b0, 32'h0000_0001, "restart keep", 0);
        ecnt = 32'h0000_0001;
        // Pulses two ticks short of the gate must vanish
        for (int s = 1; s < 8; s++)
        begin
            wb(ADR_CTRL, 1'b1, ctrl(1'b1, CIC_SINGLE, 1'b0, 1'b0, 1'b0, 3'(s)),
                "", 0);
            pulses(1'b0, 8'h01, 16'((GATE_NS[s] - 25) / 4),
                16'(GATE_NS[s] / 4 + 8));
            wb(ADR_LIVE_CNT, 1'b0, ecnt, "blocked", 0);
            pulses(1'b0, 8'h01, 16'(GATE_NS[s] / 4), 16'(GATE_NS[s] / 4 + 8));
            ecnt = ecnt + 32'h0000_0001;
            wb(ADR_LIVE_CNT, 1'b0, ecnt, "passed", 0);
        end
        start(ctrl(1'b1, CIC_FREQ, 1'b0, 1'b1, 1'b0, FILT_OFF));
        // Sample lands 125 clocks after the third rise: 40 ticks of 80
        fork
            pulses(1'b0, 8'h03, 16'h007d, 16'h007d);
            begin
                repeat (626) @(posedge clk);
                smp();
            end
        join
        wb(ADR_SMP_CNT, 1'b0, 32'h0000_0003, "smp cnt", 0);
        wb(ADR_SMP_PER, 1'b0, 32'h0000_0050, "period", 0);
        wb(ADR_SMP_FRAC, 1'b0, 32'h0000_0080, "frac", 4);
        smp();
        wb(ADR_SMP_PER, 1'b0, 32'h0000_0050, "hold", 0);
        wb(ADR_SMP_CNT, 1'b0, 32'h0000_0003, "smp cnt 2", 0);
        wb(ADR_CTRL, 1'b1, ctrl(1'b1, CIC_FREQ, 1'b0, 1'b1, 1'b1, FILT_OFF),
            "", 0);
        smp();
        wb(ADR_SMP_PER, 1'b0, 32'h0000_0000, "zero", 0);
        wb(ADR_STAT, 1'b0, 32'h0000_0010, "status", 0);
        results();
    end

    // Runs take about 14000 clocks; this limit leaves wide margin
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        results();
    end
endmodule : testbench
